/* File: design/card_bus_cfg.svh */
// Offsets, field positions, reset values and timing counts of the card host bus link
`ifndef CARD_BUS_CFG_SVH
`define CARD_BUS_CFG_SVH
`define CLK_PERIOD_NS 100
`define NS_CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_SETUP_NS 100
`define T_STROBE_NS 800
`define T_HOLD_NS 400
`define T_IRQ_PULSE_NS 500
`define T_BUSY_NS 2000
`define SETUP_CYC `NS_CYC_UP(`T_SETUP_NS)
`define STROBE_CYC `NS_CYC_UP(`T_STROBE_NS)
`define HOLD_CYC `NS_CYC_UP(`T_HOLD_NS)
`define IRQ_PULSE_CYC `NS_CYC_UP(`T_IRQ_PULSE_NS)
`define BUSY_CYC `NS_CYC_UP(`T_BUSY_NS)
`define ADDR_DATA 3'h0
`define ADDR_DEVHEAD 3'h6
`define ADDR_STATUS 3'h7
`define ADDR_DEVCTL 3'h6
`define ADDR_COR 4'h0
`define DEV_BIT 4
`define NIEN_BIT 1
`define SRST_BIT 2
`define COR_IDX_MSB 5
`define COR_LEVEL_BIT 6
`define COR_SRST_BIT 7
`define ST_BSY 7
`define ST_RDY 6
`define ST_DRQ 3
`define COR_RST 8'h00
`define CIS_FILL 8'hff
`define BUS_IDLE 16'hffff
`endif

/* File: design/card_bus_pkg.sv */
// Types of the card host bus link: card modes for the card end, commands and states for the host end
package card_bus_pkg;
  typedef enum logic [1:0] {
    MODE_MEM = 2'b00,
    MODE_IO = 2'b01,
    MODE_IDE = 2'b10
  } card_mode_t;
  typedef enum logic [2:0] {
    CMD_MEM_RD = 3'b000,
    CMD_MEM_WR = 3'b001,
    CMD_ATTR_RD = 3'b010,
    CMD_ATTR_WR = 3'b011,
    CMD_IO_RD = 3'b100,
    CMD_IO_WR = 3'b101,
    CMD_DMA_RD = 3'b110,
    CMD_DMA_WR = 3'b111
  } host_cmd_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_DMA_WAIT = 3'b001,
    H_SETUP = 3'b010,
    H_STROBE = 3'b011,
    H_HOLD = 3'b100
  } host_state_t;
endpackage : card_bus_pkg

/* File: design/card_bus_if.sv */
// Pin bundle between host controller and card, with bus resolution
`timescale 1ns/1ns
interface card_bus_if #(parameter int DATA_W = 16);
  logic [3:0] addr;
  logic [1:0] ce_n;
  logic reg_n, oe_n, we_n, iord_n, iowr_n, dmack_n, mode_sel_n, card_reset, csel_n;
  logic [DATA_W-1:0] host_d;
  logic host_doe;
  logic [DATA_W-1:0] card_d;
  logic card_doe, inpack_n, dmarq, dmarq_oe, rdy_irq;
  logic [DATA_W-1:0] dbus;
  logic dmarq_w;
  // Undriven data lines float high; undriven request reads low
  assign dbus = card_doe ? card_d : (host_doe ? host_d : {DATA_W{1'b1}});
  assign dmarq_w = dmarq_oe & dmarq;
  modport card (
    input addr, ce_n, reg_n, oe_n, we_n, iord_n, iowr_n, dmack_n, mode_sel_n, card_reset,
    input csel_n, dbus,
    output card_d, card_doe, inpack_n, dmarq, dmarq_oe, rdy_irq
  );
  modport host (
    output addr, ce_n, reg_n, oe_n, we_n, iord_n, iowr_n, dmack_n, mode_sel_n, card_reset,
    output csel_n, host_d, host_doe,
    input dbus, inpack_n, dmarq_w, rdy_irq
  );
endinterface : card_bus_if

/* File: design/sync_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module sync_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r, rd_ptr_r;
  logic [AW:0] count_r;
  logic push, pop;
  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data;
  end
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      if (push && !pop)
        count_r <= count_r + 1'b1;
      else if (pop && !push)
        count_r <= count_r - 1'b1;
    end
  end
endmodule : sync_fifo

/* File: design/card_end.sv */
// Card end: strobe handling, register access, DMA request and ready/interrupt pin
`timescale 1ns/1ns
`include "card_bus_cfg.svh"
module card_end
  import card_bus_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int FIFO_DEPTH = 4,
  parameter int BUSY_CYC = `BUSY_CYC
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  card_bus_if.card bus,
  output logic [DATA_W-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic [DATA_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic irq_event,
  input wire logic dma_start,
  input wire logic dma_to_host,
  input wire logic [15:0] dma_words,
  output logic dma_busy,
  output card_mode_t mode
);
  localparam int NS = 5;
  logic [NS-1:0] pin_w, s1_r, s2_r, s3_r, rise_w;
  logic [7:0] tf_r [8];
  logic [7:0] cor_r;
  logic nien_r, never_low_r, irq_pend_r, dma_dir_r;
  logic [15:0] busy_cnt_r, dma_left_r, dma_left_nxt;
  logic [7:0] pulse_cnt_r;
  card_mode_t mode_r;
  logic inpack_r, dmarq_r, dmarq_oe_r, rdy_r, doe_r, tx_ready_r, dma_busy_r;
  logic [DATA_W-1:0] dout_r;
  logic ide, io, dev_sel, host_sel, ctl_blk, attr, dma_act, dma_cyc;
  logic iord_lo, oe_lo, dmack_lo, io_acc, mem_acc, rd_oe, rd_io, rd_dma;
  logic reg_end, dma_rd_end, wr_attr, wr_reg, wr_dma, data_adr, busy, soft_rst, push_w;
  logic fifo_in_ready;
  logic [2:0] ra;
  logic [7:0] status_w;
  logic [DATA_W-1:0] reg_val, attr_val;

  // Only the second stage feeds the edge stage and the logic
  assign pin_w = {bus.dmack_n, bus.we_n, bus.oe_n, bus.iowr_n, bus.iord_n};
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
    end
    else
    begin
      s1_r <= pin_w;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign rise_w = s2_r & ~s3_r;
  assign iord_lo = !s2_r[0];
  assign oe_lo = !s2_r[2];
  assign dmack_lo = !s2_r[4];

  assign ide = (mode_r == MODE_IDE);
  assign io = (mode_r == MODE_IO);
  assign ra = bus.addr[2:0];
  assign dev_sel = (tf_r[`ADDR_DEVHEAD][`DEV_BIT] == bus.csel_n);
  assign host_sel = ide ? (dev_sel && (bus.ce_n != 2'b11)) : (bus.ce_n != 2'b11);
  assign ctl_blk = ide ? !bus.ce_n[1] : bus.addr[3];
  assign attr = !ide && !bus.reg_n;
  assign dma_act = (dma_left_r != 16'h0000);
  assign dma_cyc = ide && dma_act && dmack_lo && (bus.ce_n == 2'b11);
  assign io_acc = (io || ide) && host_sel && (ide || attr) && !dma_cyc;
  assign mem_acc = !ide && host_sel && (!io || attr);
  assign rd_oe = mem_acc && oe_lo;
  assign rd_io = io_acc && iord_lo;
  assign rd_dma = dma_cyc && dma_dir_r && iord_lo;
  assign reg_end = (mem_acc && !attr && rise_w[2]) || (io_acc && rise_w[0]);
  assign dma_rd_end = dma_cyc && dma_dir_r && rise_w[0];
  assign wr_attr = mem_acc && attr && rise_w[3];
  assign wr_reg = (mem_acc && !attr && rise_w[3]) || (io_acc && rise_w[1]);
  assign wr_dma = dma_cyc && !dma_dir_r && rise_w[1];
  assign data_adr = !ctl_blk && (ra == `ADDR_DATA);
  assign busy = (busy_cnt_r != 16'h0000);
  assign soft_rst = (wr_reg && ctl_blk && ra == `ADDR_DEVCTL && bus.dbus[`SRST_BIT])
    || (wr_attr && bus.addr == `ADDR_COR && bus.dbus[`COR_SRST_BIT]);
  assign push_w = (wr_reg && data_adr) || wr_dma;

  always_comb
  begin
    status_w = 8'h00;
    status_w[`ST_BSY] = busy;
    status_w[`ST_RDY] = !busy;
    status_w[`ST_DRQ] = tx_valid;
    attr_val = {8'h00, (bus.addr == `ADDR_COR) ? cor_r : `CIS_FILL};
    if (ctl_blk || ra == `ADDR_STATUS)
      reg_val = {8'h00, status_w};
    else if (ra == `ADDR_DATA)
      reg_val = tx_data;
    else
      reg_val = {8'h00, tf_r[ra]};
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      doe_r <= 1'b0;
      dout_r <= `BUS_IDLE;
      inpack_r <= 1'b1;
      tx_ready_r <= 1'b0;
    end
    else
    begin
      doe_r <= rd_oe || rd_io || rd_dma;
      dout_r <= rd_dma ? tx_data : ((rd_oe && attr) ? attr_val : reg_val);
      inpack_r <= !(io && rd_io);
      tx_ready_r <= tx_valid && ((reg_end && data_adr) || dma_rd_end);
    end
  end

  // Task file and device control
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 8; i++)
        tf_r[i] <= 8'h00;
      nien_r <= 1'b0;
    end
    else if (wr_reg && !data_adr && ctl_blk && ra == `ADDR_DEVCTL)
      nien_r <= bus.dbus[`NIEN_BIT];
    else if (wr_reg && !data_adr && !ctl_blk)
      tf_r[ra] <= bus.dbus[7:0];
  end

  // Mode, configuration and reset processing
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_r <= MODE_MEM;
      cor_r <= `COR_RST;
      never_low_r <= 1'b1;
      busy_cnt_r <= 16'(BUSY_CYC);
    end
    else
    begin
      mode_r <= !bus.mode_sel_n ? MODE_IDE
        : ((cor_r[`COR_IDX_MSB:0] != 6'h00) ? MODE_IO : MODE_MEM);
      if (!bus.card_reset)
        never_low_r <= 1'b0;
      if (bus.card_reset && !never_low_r)
        cor_r <= `COR_RST;
      else if (wr_attr && bus.addr == `ADDR_COR)
        cor_r <= bus.dbus[7:0];
      if ((bus.card_reset && !never_low_r) || soft_rst)
        busy_cnt_r <= 16'(BUSY_CYC);
      else if (busy)
        busy_cnt_r <= busy_cnt_r - 16'h0001;
    end
  end

  // DMA word count and request handshake
  always_comb
  begin
    dma_left_nxt = dma_left_r;
    if (bus.card_reset && !never_low_r)
      dma_left_nxt = 16'h0000;
    else if (dma_start)
      dma_left_nxt = dma_words;
    else if ((wr_dma || dma_rd_end) && dma_act)
      dma_left_nxt = dma_left_r - 16'h0001;
  end
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dma_left_r <= 16'h0000;
      dma_dir_r <= 1'b0;
      dma_busy_r <= 1'b0;
      dmarq_r <= 1'b0;
      dmarq_oe_r <= 1'b0;
    end
    else
    begin
      dma_left_r <= dma_left_nxt;
      dma_busy_r <= (dma_left_nxt != 16'h0000);
      if (dma_start)
        dma_dir_r <= dma_to_host;
      if (!ide || !dma_act || dmack_lo)
        dmarq_r <= 1'b0;
      else
        dmarq_r <= dma_dir_r ? tx_valid : fifo_in_ready;
      dmarq_oe_r <= ide && dev_sel;
    end
  end

  // Interrupt state and the shared ready/interrupt pin
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_pend_r <= 1'b0;
      pulse_cnt_r <= 8'h00;
      rdy_r <= 1'b0;
    end
    else
    begin
      if (irq_event)
        irq_pend_r <= 1'b1;
      else if (reg_end && !ctl_blk && ra == `ADDR_STATUS)
        irq_pend_r <= 1'b0;
      if (irq_event && io && !cor_r[`COR_LEVEL_BIT])
        pulse_cnt_r <= 8'(`IRQ_PULSE_CYC);
      else if (pulse_cnt_r != 8'h00)
        pulse_cnt_r <= pulse_cnt_r - 8'h01;
      unique case (mode_r)
        MODE_IDE: rdy_r <= irq_pend_r && !nien_r;
        MODE_IO:
          rdy_r <= cor_r[`COR_LEVEL_BIT] ? !irq_pend_r : (pulse_cnt_r == 8'h00);
        MODE_MEM:
          rdy_r <= never_low_r || (!busy && fifo_in_ready);
        default: rdy_r <= 1'b1;
      endcase
    end
  end

  sync_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .in_valid(push_w),
    .in_ready(fifo_in_ready),
    .in_data(bus.dbus),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  assign bus.card_d = dout_r;
  assign bus.card_doe = doe_r;
  assign bus.inpack_n = inpack_r;
  assign bus.dmarq = dmarq_r;
  assign bus.dmarq_oe = dmarq_oe_r;
  assign bus.rdy_irq = rdy_r;
  assign tx_ready = tx_ready_r;
  assign dma_busy = dma_busy_r;
  assign mode = mode_r;
endmodule : card_end

/* File: design/host_end.sv */
// Host end: runs one strobed bus cycle per command, DMA words on request
`timescale 1ns/1ns
`include "card_bus_cfg.svh"
module host_end
  import card_bus_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int SETUP_CYC = `SETUP_CYC,
  parameter int STROBE_CYC = `STROBE_CYC,
  parameter int HOLD_CYC = `HOLD_CYC,
  parameter bit CARD_MASTER = 1'b1
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  card_bus_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire host_cmd_t cmd_kind,
  input wire logic [3:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_wdata,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  output logic rsp_nack,
  input wire logic ide_mode,
  input wire logic card_reset_req,
  output logic irq_level
);
  host_state_t state_r;
  host_cmd_t kind_r;
  logic [7:0] cnt_r;
  logic [3:0] addr_r, strb_n_r;
  logic [1:0] ce_r;
  logic reg_r, dmack_r, doe_r, ready_r, rvalid_r, nack_r, mode_n_r, rst_r, csel_r, irq_r;
  logic [DATA_W-1:0] dout_r, rdata_r;
  logic gate_off;

  // One-hot active strobe {iowr, iord, we, oe} for a command
  function automatic logic [3:0] strobe_of(input host_cmd_t k);
    unique case (k)
      CMD_MEM_RD, CMD_ATTR_RD: strobe_of = 4'h1;
      CMD_MEM_WR, CMD_ATTR_WR: strobe_of = 4'h2;
      CMD_IO_RD, CMD_DMA_RD: strobe_of = 4'h4;
      CMD_IO_WR, CMD_DMA_WR: strobe_of = 4'h8;
    endcase
  endfunction : strobe_of

  // Outside IDE mode, I/O read data only enters when the card acknowledges it
  assign gate_off = (kind_r == CMD_IO_RD) && !ide_mode && bus.inpack_n;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= H_IDLE;
      kind_r <= CMD_MEM_RD;
      cnt_r <= 8'h00;
      addr_r <= 4'h0;
      strb_n_r <= 4'hf;
      ce_r <= 2'b11;
      reg_r <= 1'b1;
      dmack_r <= 1'b1;
      doe_r <= 1'b0;
      dout_r <= `BUS_IDLE;
      ready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= `BUS_IDLE;
      nack_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= 1'b0;
      unique case (state_r)
        H_IDLE:
        begin
          ready_r <= 1'b1;
          if (cmd_valid && ready_r)
          begin
            ready_r <= 1'b0;
            kind_r <= cmd_kind;
            addr_r <= cmd_addr;
            dout_r <= cmd_wdata;
            doe_r <= cmd_kind[0];
            reg_r <= !(cmd_kind inside {CMD_ATTR_RD, CMD_ATTR_WR, CMD_IO_RD, CMD_IO_WR});
            cnt_r <= 8'(SETUP_CYC - 1);
            if (cmd_kind inside {CMD_DMA_RD, CMD_DMA_WR})
            begin
              ce_r <= 2'b11;
              state_r <= H_DMA_WAIT;
            end
            else
            begin
              ce_r <= !ide_mode ? 2'b00 : (cmd_addr[3] ? 2'b01 : 2'b10);
              state_r <= H_SETUP;
            end
          end
        end
        H_DMA_WAIT:
          if (bus.dmarq_w)
          begin
            dmack_r <= 1'b0;
            state_r <= H_SETUP;
          end
        H_SETUP:
          if (cnt_r == 8'h00)
          begin
            strb_n_r <= ~strobe_of(kind_r);
            cnt_r <= 8'(STROBE_CYC - 1);
            state_r <= H_STROBE;
          end
          else
            cnt_r <= cnt_r - 8'h01;
        H_STROBE:
          if (cnt_r == 8'h00)
          begin
            rdata_r <= gate_off ? `BUS_IDLE : bus.dbus;
            nack_r <= gate_off;
            strb_n_r <= 4'hf;
            cnt_r <= 8'(HOLD_CYC - 1);
            state_r <= H_HOLD;
          end
          else
            cnt_r <= cnt_r - 8'h01;
        H_HOLD:
          if (cnt_r == 8'h00)
          begin
            doe_r <= 1'b0;
            dmack_r <= 1'b1;
            ce_r <= 2'b11;
            reg_r <= 1'b1;
            rvalid_r <= 1'b1;
            state_r <= H_IDLE;
          end
          else
            cnt_r <= cnt_r - 8'h01;
        default:
          state_r <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_n_r <= 1'b1;
      rst_r <= 1'b0;
      csel_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      mode_n_r <= !ide_mode;
      rst_r <= card_reset_req;
      csel_r <= !CARD_MASTER;
      irq_r <= bus.rdy_irq;
    end
  end

  assign bus.addr = addr_r;
  assign bus.ce_n = ce_r;
  assign bus.reg_n = reg_r;
  assign bus.oe_n = strb_n_r[0];
  assign bus.we_n = strb_n_r[1];
  assign bus.iord_n = strb_n_r[2];
  assign bus.iowr_n = strb_n_r[3];
  assign bus.dmack_n = dmack_r;
  assign bus.host_d = dout_r;
  assign bus.host_doe = doe_r;
  assign bus.mode_sel_n = mode_n_r;
  assign bus.card_reset = rst_r;
  assign bus.csel_n = csel_r;
  assign cmd_ready = ready_r;
  assign rsp_valid = rvalid_r;
  assign rsp_data = rdata_r;
  assign rsp_nack = nack_r;
  assign irq_level = irq_r;
endmodule : host_end

/* File: tb/card_bus_properties.sv */
// Timing checks on the pins between host end and card end
`timescale 1ns/1ns
module card_bus_properties
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [3:0] addr,
  input wire logic [1:0] ce_n,
  input wire logic reg_n,
  input wire logic oe_n,
  input wire logic iord_n,
  input wire logic dmack_n,
  input wire logic mode_sel_n,
  input wire logic card_reset,
  input wire logic host_doe,
  input wire logic card_doe,
  input wire logic inpack_n,
  input wire logic dmarq_oe,
  input wire logic dmarq_w,
  input wire logic rdy_irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  a_inpack_io_read: assert property ($fell(inpack_n) |->
    !$past(iord_n, 2) && ce_n != 2'b11)
    else $error("input acknowledge without a read strobe");
  a_dmarq_ide_only: assert property (dmarq_oe |-> !mode_sel_n)
    else $error("request pin driven outside IDE mode");
  a_dmarq_rise_idle: assert property ($rose(dmarq_w) |-> dmack_n)
    else $error("request raised while acknowledge low");
  a_dmarq_ack_drop: assert property ($fell(dmack_n) |-> ##[1:4] !dmarq_w)
    else $error("request kept after acknowledge");
  a_dma_cs_negated: assert property (!dmack_n |-> ce_n == 2'b11)
    else $error("chip select active during DMA");
  a_doe_read_cause: assert property ($rose(card_doe) |->
    !$past(iord_n, 2) || !$past(oe_n, 2))
    else $error("card drives data without read strobe");
  a_doe_stands: assert property ($rose(card_doe) |-> card_doe [*5])
    else $error("read data released early");
  a_bus_one_driver: assert property (!(card_doe && host_doe))
    else $error("both ends drive the data bus");
  a_strobe_sync_delay: assert property ($fell(iord_n) || $fell(oe_n) |->
    !card_doe [*3])
    else $error("data driven before strobe synchronised");
  a_busy_on_reset: assert property ($rose(card_reset) && mode_sel_n |->
    ##[1:6] !rdy_irq)
    else $error("ready not low after card reset");
  a_ide_irq_clear: assert property ($rose(iord_n) && !mode_sel_n && ce_n == 2'b10
    && addr == 4'h7 |-> ##[2:6] !rdy_irq)
    else $error("status read left interrupt high");
  c_inpack: cover property ($fell(inpack_n));
  c_dma_ack: cover property ($fell(dmack_n));
  c_ide_read: cover property ($rose(card_doe) && !mode_sel_n);
  c_io_irq: cover property ($fell(rdy_irq) && mode_sel_n);
endmodule : card_bus_properties

/* File: tb/test_card_host_bus_handshake.sv */
// Both ends joined over the pin bundle, driven from their user sides
`timescale 1ns/1ns
`include "card_bus_cfg.svh"
module test_card_host_bus_handshake;
  import card_bus_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] rx_data, tx_data = 16'h0000, cmd_wdata = 16'h0000, rsp_data, dma_words = 16'h0000;
  logic rx_valid, rx_ready = 1'b0, tx_valid = 1'b0, tx_ready, irq_event = 1'b0, dma_start = 1'b0;
  logic dma_to_host = 1'b0, dma_busy, cmd_valid = 1'b0, cmd_ready, rsp_valid, rsp_nack;
  logic ide_mode = 1'b0, card_reset_req = 1'b0, irq_level;
  logic [3:0] cmd_addr = 4'h0;
  host_cmd_t cmd_kind = CMD_MEM_RD;
  card_mode_t mode;
  logic [15:0] rd;
  logic nk;
  int n_mismatch = 0, cmp_count = 0, tx_count = 0;
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (tx_ready === 1'b1) tx_count <= tx_count + 1;
  card_bus_if card_bus_if_inst ();
  card_end #(.BUSY_CYC(4)) card_end_inst (.sys_clk(sys_clk), .resetn(resetn),
    .bus(card_bus_if_inst.card), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .irq_event(irq_event),
    .dma_start(dma_start), .dma_to_host(dma_to_host), .dma_words(dma_words),
    .dma_busy(dma_busy), .mode(mode));
  host_end host_end_inst (.sys_clk(sys_clk), .resetn(resetn), .bus(card_bus_if_inst.host),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack),
    .ide_mode(ide_mode), .card_reset_req(card_reset_req), .irq_level(irq_level));
  card_bus_properties card_bus_properties_inst (.sys_clk(sys_clk), .resetn(resetn),
    .addr(card_bus_if_inst.addr), .ce_n(card_bus_if_inst.ce_n), .reg_n(card_bus_if_inst.reg_n),
    .oe_n(card_bus_if_inst.oe_n), .iord_n(card_bus_if_inst.iord_n),
    .dmack_n(card_bus_if_inst.dmack_n), .mode_sel_n(card_bus_if_inst.mode_sel_n),
    .card_reset(card_bus_if_inst.card_reset), .host_doe(card_bus_if_inst.host_doe),
    .card_doe(card_bus_if_inst.card_doe), .inpack_n(card_bus_if_inst.inpack_n),
    .dmarq_oe(card_bus_if_inst.dmarq_oe), .dmarq_w(card_bus_if_inst.dmarq_w),
    .rdy_irq(card_bus_if_inst.rdy_irq));
  task automatic step(input int k = 1);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : step
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask : check
  task automatic timeout(input string nm);
    $display("[FAIL] %s expected done seen timeout", nm);
    n_mismatch++;
    stop_test();
  endtask : timeout
  // One host command, waits for its response
  task automatic do_cmd(input host_cmd_t k, input logic [3:0] a, input logic [15:0] wd);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 200)
    begin
      step();
      n++;
    end
    if (n >= 200) timeout("cmd_ready");
    cmd_kind = k;
    cmd_addr = a;
    cmd_wdata = wd;
    cmd_valid = 1'b1;
    step();
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 400)
    begin
      step();
      n++;
    end
    if (n >= 400) timeout("rsp_valid");
    rd = rsp_data;
    nk = rsp_nack;
    step();
  endtask : do_cmd
  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (irq_level !== v && n < 100)
    begin
      step();
      n++;
    end
    if (n >= 100) timeout("irq_level");
  endtask : wait_irq
  task automatic pulse_event;
    irq_event = 1'b1;
    step();
    irq_event = 1'b0;
  endtask : pulse_event
  task automatic drain(input int cnt, input logic [15:0] base);
    for (int i = 0; i < cnt; i++)
    begin
      check("rx_data", base + 16'(i), rx_data);
      rx_ready = 1'b1;
      step();
      rx_ready = 1'b0;
    end
    check("rx_valid", 16'h0000, {15'h0000, rx_valid});
  endtask : drain
  task automatic t_mem_mode;
    wait_irq(1'b1);
    check("mode", 16'(MODE_MEM), 16'(mode));
    card_reset_req = 1'b1;
    step(3);
    card_reset_req = 1'b0;
    step(2);
    check("ready busy", 16'h0000, {15'h0000, irq_level});
    wait_irq(1'b1);
    do_cmd(CMD_IO_RD, 4'h7, 16'h0000);
    check("mem io nack", 16'h0001, {15'h0000, nk});
    check("mem io data", `BUS_IDLE, rd);
    do_cmd(CMD_ATTR_RD, 4'h2, 16'h0000);
    check("attr fill", 16'(`CIS_FILL), {8'h00, rd[7:0]});
  endtask : t_mem_mode
  task automatic t_io_mode;
    int n;
    do_cmd(CMD_ATTR_WR, `ADDR_COR, 16'h0041);
    step(2);
    check("mode io", 16'(MODE_IO), 16'(mode));
    do_cmd(CMD_ATTR_RD, `ADDR_COR, 16'h0000);
    check("cor read", 16'h0041, {8'h00, rd[7:0]});
    do_cmd(CMD_IO_RD, 4'h7, 16'h0000);
    check("io nack", 16'h0000, {15'h0000, nk});
    check("io status", 16'h0040, rd);
    pulse_event();
    wait_irq(1'b0);
    step(10);
    check("level held", 16'h0000, {15'h0000, irq_level});
    do_cmd(CMD_IO_RD, 4'h7, 16'h0000);
    wait_irq(1'b1);
    do_cmd(CMD_ATTR_WR, `ADDR_COR, 16'h0001);
    pulse_event();
    wait_irq(1'b0);
    n = 0;
    while (irq_level === 1'b0 && n < 50)
    begin
      step();
      n++;
    end
    check("pulse length", 16'(`IRQ_PULSE_CYC), 16'(n));
  endtask : t_io_mode
  task automatic t_ide_regs;
    int c0;
    ide_mode = 1'b1;
    step(4);
    check("mode ide", 16'(MODE_IDE), 16'(mode));
    do_cmd(CMD_IO_WR, 4'h2, 16'h12a5);
    do_cmd(CMD_IO_RD, 4'h2, 16'h0000);
    check("task reg", 16'h00a5, rd);
    for (int i = 0; i < 5; i++) do_cmd(CMD_IO_WR, {1'b0, `ADDR_DATA}, 16'h1000 + 16'(i));
    drain(4, 16'h1000);
    c0 = tx_count;
    tx_data = 16'hc3c3;
    tx_valid = 1'b1;
    do_cmd(CMD_IO_RD, {1'b0, `ADDR_DATA}, 16'h0000);
    tx_valid = 1'b0;
    check("data read", 16'hc3c3, rd);
    check("tx taken", 16'h0001, 16'(tx_count - c0));
    // Clear any request left pending by the I/O mode scenario
    do_cmd(CMD_IO_RD, {1'b0, `ADDR_STATUS}, 16'h0000);
    step(2);
    check("ide irq idle", 16'h0000, {15'h0000, irq_level});
    pulse_event();
    wait_irq(1'b1);
    do_cmd(CMD_IO_RD, {1'b0, `ADDR_STATUS}, 16'h0000);
    wait_irq(1'b0);
  endtask : t_ide_regs
  task automatic t_dma;
    dma_to_host = 1'b0;
    dma_words = 16'h0002;
    dma_start = 1'b1;
    step();
    dma_start = 1'b0;
    for (int i = 0; i < 2; i++) do_cmd(CMD_DMA_WR, 4'h0, 16'ha000 + 16'(i));
    step(4);
    check("dma busy", 16'h0000, {15'h0000, dma_busy});
    drain(2, 16'ha000);
    tx_data = 16'h5a5a;
    tx_valid = 1'b1;
    dma_to_host = 1'b1;
    dma_words = 16'h0001;
    dma_start = 1'b1;
    step();
    dma_start = 1'b0;
    do_cmd(CMD_DMA_RD, 4'h0, 16'h0000);
    tx_valid = 1'b0;
    check("dma read", 16'h5a5a, rd);
    step(4);
    check("dma done", 16'h0000, {15'h0000, dma_busy});
  endtask : t_dma
  initial
  begin
    step(8);
    resetn = 1'b1;
    t_mem_mode();
    t_io_mode();
    t_ide_regs();
    t_dma();
    stop_test();
  end
endmodule : test_card_host_bus_handshake
